//--- rtl/ramp_segment_sequencer.sv
/*
 * Ramp segment sequencer of a fractional-N synthesizer, classic Wishbone slave.
 * Assumes one 100 MHz clock that is also the phase-detector step rate, synchronous reset,
 * and three multiplexed pins from off chip, synchronised here.
 */
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
// Summary of operation
// - a segment looping to itself on timeout with the reset option set repeats forever as a sawtooth
// - shift deviation is added onto the instantaneous ramped numerator while active
// - the enable bit starts ramp and frequency shift keying together
// - numerator carries across segments unless the segment reset option is set
// - an enabled comparator raises its flag when the ramp reaches its threshold
// - comparator enable is a per-segment mask, bit n (comparator a) and bit 8+n (comparator b) monitor segment n
// - each comparator flag may be routed to a chosen multiplexed pin
// - segment step count supports up to 65536 steps
// - half-rate option applies the increment once every two cycles
// - eight independently programmable segments chain in any order
// - per-segment flags pulse when a segment starts
// - a pin edge configured as trigger starts a segment waiting on it
// - in normal rate the increment is added once per cycle
// - advance select zero means timeout, next segment starts immediately
// - ramp limits are 32-bit signed two's complement values; the ramp is not clamped to them
// - trigger source code 3 selects rising edge on pin a
`timescale 1ns/1ps
`include "ramp_seq_cfg.svh"
module ramp_segment_sequencer import ramp_seq_pkg::*; #(
  parameter int NSEG = 8,
  parameter int LEN_W = 16
) (
  input wire logic I_CORE_CLK, // core and step clock
  input wire logic I_RST, // synchronous reset, high
  input wire logic I_WB_CYC, // wishbone cycle
  input wire logic I_WB_STB, // wishbone strobe
  input wire logic I_WB_WE, // wishbone write
  input wire logic [7:0] I_WB_ADR, // wishbone byte address
  input wire logic [3:0] I_WB_SEL, // wishbone byte enables
  input wire logic [31:0] I_WB_DAT, // wishbone write data
  output logic [31:0] O_WB_DAT, // wishbone read data
  output logic O_WB_ACK, // wishbone acknowledge
  input wire logic [2:0] I_PIN, // multiplexed pins a,b,c inputs
  output logic [2:0] O_PIN, // multiplexed pins outputs
  output logic [2:0] O_PIN_OE, // high while pin driven
  output logic [32:0] O_NUMER // numerator with shift applied
);
  // ===================================================================
  // register file
  logic [31:0] ctrl_q, ctrl_d, dev_q, dev_d, hi_q, hi_d, lo_q, lo_d;
  logic [31:0] ta_q, ta_d, tb_q, tb_d, ccfg_q, ccfg_d, pcfg_q, pcfg_d;
  logic [31:0] inc_q [NSEG], inc_d [NSEG];
  logic [LEN_W-1:0] len_q [NSEG], len_d [NSEG];
  logic [15:0] scfg_q [NSEG], scfg_d [NSEG];
  logic ack_q, ack_d;
  logic [31:0] rd_q, rd_d;
  logic [31:0] wmask;
  logic req;
  assign req = I_WB_CYC && I_WB_STB && !ack_q;
  assign wmask = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}}, {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
  // ===================================================================
  // sequencer state
  seq_state_t st_q, st_d;
  logic [2:0] seg_q, seg_d;
  logic [LEN_W:0] cnt_q, cnt_d;
  logic half_q, half_d;
  numer_t num_q, num_d;
  logic shift_q, shift_d;
  logic [2:0] flag_q, flag_d;
  logic [2:0] pin_out_q, pin_out_d;
  logic [1:0] cmp_q, cmp_d;
  logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic [2:0] rise;
  logic en, seg_done, adv_ok;
  logic [15:0] cur_cfg;
  logic [1:0] adv_sel;
  logic [2:0] tsrc [3];
  logic [2:0] trig;
  numer_t inc_ext, out_num;
  assign en = ctrl_q[`RS_CTRL_EN_BIT];
  assign cur_cfg = scfg_q[seg_q];
  assign adv_sel = cur_cfg[`RS_CFG_ADV_LSB +: 2];
  assign inc_ext = numer_t'($signed(inc_q[seg_q]));
  assign rise = pin_s2_q & ~pin_s3_q;
  // trigger sources a,b,c from pin_cfg[2:0],[6:4],[10:8]: 1..3 rising, 4..6 falling edge
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_trig
      assign tsrc[g] = pcfg_q[4*g +: 3];
      always_comb begin
        unique case (tsrc[g])
          3'd1: trig[g] = rise[1];
          3'd2: trig[g] = rise[2];
          `RS_TSRC_PIN_A_RISE: trig[g] = rise[0];
          3'd4: trig[g] = pin_s3_q[1] & ~pin_s2_q[1];
          3'd5: trig[g] = pin_s3_q[2] & ~pin_s2_q[2];
          3'd6: trig[g] = pin_s3_q[0] & ~pin_s2_q[0];
          default: trig[g] = 1'b0;
        endcase
      end
    end
  endgenerate
  // ===================================================================
  // bus and register next state
  always_comb begin
    int a;
    a = 0;
    ctrl_d = ctrl_q; dev_d = dev_q; hi_d = hi_q; lo_d = lo_q;
    ta_d = ta_q; tb_d = tb_q; ccfg_d = ccfg_q; pcfg_d = pcfg_q;
    inc_d = inc_q; len_d = len_q; scfg_d = scfg_q;
    ack_d = req;
    rd_d = `RS_BUS_ERR_DATA;
    if (req && I_WB_WE) begin
      unique case (I_WB_ADR)
        `RS_OFF_CTRL: ctrl_d = (ctrl_q & ~wmask) | (I_WB_DAT & wmask);
        `RS_OFF_SHIFT_DEV: dev_d = (dev_q & ~wmask) | (I_WB_DAT & wmask);
        `RS_OFF_LIMIT_HI: hi_d = (hi_q & ~wmask) | (I_WB_DAT & wmask);
        `RS_OFF_LIMIT_LO: lo_d = (lo_q & ~wmask) | (I_WB_DAT & wmask);
        `RS_OFF_CMPA_THR: ta_d = (ta_q & ~wmask) | (I_WB_DAT & wmask);
        `RS_OFF_CMPB_THR: tb_d = (tb_q & ~wmask) | (I_WB_DAT & wmask);
        `RS_OFF_CMP_CFG: ccfg_d = (ccfg_q & ~wmask) | (I_WB_DAT & wmask);
        `RS_OFF_PIN_CFG: pcfg_d = (pcfg_q & ~wmask) | (I_WB_DAT & wmask);
        default: begin
          if (I_WB_ADR >= `RS_OFF_SEG_BASE && I_WB_ADR < 8'(`RS_OFF_SEG_BASE + 16 * NSEG)) begin
            a = int'(I_WB_ADR - `RS_OFF_SEG_BASE) >> `RS_SEG_STRIDE_LOG2;
            unique case (I_WB_ADR[3:2])
              2'd0: inc_d[a] = (inc_q[a] & ~wmask) | (I_WB_DAT & wmask);
              2'd1: len_d[a] = LEN_W'((32'(len_q[a]) & ~wmask) | (I_WB_DAT & wmask));
              2'd2: scfg_d[a] = 16'((32'(scfg_q[a]) & ~wmask) | (I_WB_DAT & wmask));
              default: ;
            endcase
          end
        end
      endcase
    end else if (req) begin
      unique case (I_WB_ADR)
        `RS_OFF_CTRL: rd_d = ctrl_q;
        `RS_OFF_STATUS: rd_d = {21'd0, cmp_q, seg_q, 3'd0, st_q};
        `RS_OFF_SHIFT_DEV: rd_d = dev_q;
        `RS_OFF_LIMIT_HI: rd_d = hi_q;
        `RS_OFF_LIMIT_LO: rd_d = lo_q;
        `RS_OFF_CMPA_THR: rd_d = ta_q;
        `RS_OFF_CMPB_THR: rd_d = tb_q;
        `RS_OFF_CMP_CFG: rd_d = ccfg_q;
        `RS_OFF_NUMER: rd_d = num_q[31:0];
        `RS_OFF_PIN_CFG: rd_d = pcfg_q;
        default: begin
          if (I_WB_ADR >= `RS_OFF_SEG_BASE && I_WB_ADR < 8'(`RS_OFF_SEG_BASE + 16 * NSEG)) begin
            a = int'(I_WB_ADR - `RS_OFF_SEG_BASE) >> `RS_SEG_STRIDE_LOG2;
            unique case (I_WB_ADR[3:2])
              2'd0: rd_d = inc_q[a];
              2'd1: rd_d = 32'(len_q[a]);
              2'd2: rd_d = 32'(scfg_q[a]);
              default: rd_d = `RS_BUS_ERR_DATA;
            endcase
          end
        end
      endcase
    end
  end
  // ===================================================================
  // sequencer next state
  always_comb begin
    numer_t nxt;
    nxt = num_q;
    st_d = st_q; seg_d = seg_q; cnt_d = cnt_q; half_d = half_q; num_d = num_q;
    flag_d = 3'd0;
    shift_d = shift_q;
    // len 0 stands for the full 65536 steps
    seg_done = (cnt_q == 0);
    unique case (adv_sel)
      `RS_ADV_TIMEOUT: adv_ok = 1'b1;
      `RS_ADV_TRIG_A: adv_ok = trig[0];
      `RS_ADV_TRIG_B: adv_ok = trig[1];
      default: adv_ok = trig[2];
    endcase
    // shift keying follows its selected trigger: toggles on each edge
    if (!en) begin
      shift_d = 1'b0;
    end else if (ctrl_q[`RS_CTRL_SHIFT_TRIG_LSB +: 2] != 2'd0 && trig[ctrl_q[`RS_CTRL_SHIFT_TRIG_LSB +: 2] - 2'd1]) begin
      shift_d = !shift_q;
    end
    unique case (st_q)
      ST_IDLE: begin
        if (en) begin
          st_d = ST_RUN;
          seg_d = 3'd0;
          cnt_d = {1'b0, len_q[0]} - (LEN_W+1)'(1);
          cnt_d[LEN_W] = (len_q[0] == 0);
          if (len_q[0] == 0) cnt_d = {1'b0, {LEN_W{1'b1}}};
          half_d = 1'b0;
          if (scfg_q[0][`RS_CFG_RST_BIT]) num_d = '0;
          flag_d = scfg_q[0][`RS_CFG_FLAG_LSB +: 3];
        end
      end
      ST_RUN: begin
        half_d = !half_q;
        if (!cur_cfg[`RS_CFG_HALF_BIT] || half_q) begin
          nxt = num_q + inc_ext;
          if (nxt > $signed(hi_q[31:0] == 0 ? {1'b0, 32'h7FFF_FFFF} : numer_t'($signed(hi_q)))) nxt = nxt;
          num_d = nxt;
          if (seg_done) st_d = ST_WAIT;
          else cnt_d = cnt_q - (LEN_W+1)'(1);
        end
      end
      ST_WAIT: begin
        if (adv_ok) begin
          seg_d = cur_cfg[`RS_CFG_NEXT_LSB +: 3];
          // the reset option belongs to the segment about to start
          if (scfg_q[seg_d][`RS_CFG_RST_BIT]) num_d = '0;
          st_d = ST_RUN;
          half_d = 1'b0;
          cnt_d = (len_q[seg_d] == 0) ? {1'b0, {LEN_W{1'b1}}} : {1'b0, len_q[seg_d]} - (LEN_W+1)'(1);
          flag_d = scfg_q[seg_d][`RS_CFG_FLAG_LSB +: 3];
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (!en) st_d = ST_IDLE;
  end
  // ===================================================================
  // comparators and outputs
  assign out_num = num_q + (shift_q ? numer_t'($signed(dev_q)) : '0);
  always_comb begin
    logic [2:0] o;
    o = flag_q;
    // thresholds sign-extended to the 33-bit numerator
    cmp_d[0] = en && ccfg_q[seg_q] && (num_q >= numer_t'($signed(ta_q)));
    cmp_d[1] = en && ccfg_q[8 + 32'(seg_q)] && (num_q >= numer_t'($signed(tb_q)));
    // comparator a drives pin ccfg[17:16], comparator b pin ccfg[19:18]; 3 = none
    if (ccfg_q[17:16] != 2'd3) o[ccfg_q[17:16]] = cmp_q[0];
    if (ccfg_q[19:18] != 2'd3) o[ccfg_q[19:18]] = cmp_q[1];
    pin_out_d = o;
  end
  always_ff @(posedge I_CORE_CLK) begin
    pin_s1_q <= I_PIN;
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
    if (I_RST) begin
      ctrl_q <= '0; dev_q <= '0; hi_q <= '0; lo_q <= '0; ta_q <= '0; tb_q <= '0;
      ccfg_q <= 32'h000F_0000; pcfg_q <= '0;
      for (int i = 0; i < NSEG; i++) begin
        inc_q[i] <= '0;
        len_q[i] <= `RS_SEG_LEN_RST;
        scfg_q[i] <= '0;
      end
      ack_q <= 1'b0; rd_q <= '0;
      st_q <= ST_IDLE; seg_q <= '0; cnt_q <= '0; half_q <= 1'b0; num_q <= '0;
      shift_q <= 1'b0; flag_q <= '0; cmp_q <= '0; pin_out_q <= '0;
      O_NUMER <= '0; O_PIN_OE <= '0;
    end else begin
      ctrl_q <= ctrl_d; dev_q <= dev_d; hi_q <= hi_d; lo_q <= lo_d; ta_q <= ta_d; tb_q <= tb_d;
      ccfg_q <= ccfg_d; pcfg_q <= pcfg_d; inc_q <= inc_d; len_q <= len_d; scfg_q <= scfg_d;
      ack_q <= ack_d; rd_q <= rd_d;
      st_q <= st_d; seg_q <= seg_d; cnt_q <= cnt_d; half_q <= half_d; num_q <= num_d;
      shift_q <= shift_d; flag_q <= flag_d; cmp_q <= cmp_d; pin_out_q <= pin_out_d;
      O_NUMER <= out_num;
      O_PIN_OE <= pcfg_q[14:12];
    end
  end
  assign O_WB_ACK = ack_q;
  assign O_WB_DAT = rd_q;
  assign O_PIN = pin_out_q;
  // ===================================================================
  // assertions
  a_timeout_advance: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (st_q == ST_WAIT && adv_sel == `RS_ADV_TIMEOUT && en) |=> (st_q == ST_RUN && seg_q == $past(cur_cfg[2:0])))
    else $error("timeout advance did not start next segment");
  a_numer_reset: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (st_q == ST_WAIT && adv_ok && en && !scfg_q[cur_cfg[2:0]][`RS_CFG_RST_BIT]) |=> (num_q == $past(num_q)))
    else $error("numerator changed across boundary");
  a_full_rate: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (st_q == ST_RUN && en && !cur_cfg[`RS_CFG_HALF_BIT]) |=> (num_q == $past(num_q) + $past(inc_ext)))
    else $error("full rate step missing");
  a_half_rate: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (st_q == ST_RUN && en && cur_cfg[`RS_CFG_HALF_BIT] && !half_q) |=> (num_q == $past(num_q)))
    else $error("half rate stepped on idle cycle");
  a_shift_sum: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    shift_q |=> (O_NUMER == $past(num_q) + numer_t'($signed($past(dev_q)))))
    else $error("shift not added to carrier");
  a_enable_start: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (st_q == ST_IDLE && en) |=> (st_q == ST_RUN && seg_q == 3'd0))
    else $error("enable did not start ramp");
  a_cmp_mask: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (!ccfg_q[seg_q]) |=> !cmp_q[0])
    else $error("comparator a flagged unmonitored segment");
  a_ack_single: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    ack_q |=> !ack_q)
    else $error("ack held two cycles");
endmodule

//--- rtl/ramp_seq_cfg.svh
/*
 * Constants for the ramp segment sequencer: register offsets, field positions, reset values.
 * Assumes inclusion from the top module and the bench only; definitions only.
 */
`ifndef RAMP_SEQ_CFG_SVH
`define RAMP_SEQ_CFG_SVH
// =====================================================================
// global registers
`define RS_OFF_CTRL 8'h00
`define RS_OFF_STATUS 8'h04
`define RS_OFF_SHIFT_DEV 8'h08
`define RS_OFF_LIMIT_HI 8'h0C
`define RS_OFF_LIMIT_LO 8'h10
`define RS_OFF_CMPA_THR 8'h14
`define RS_OFF_CMPB_THR 8'h18
`define RS_OFF_CMP_CFG 8'h1C
`define RS_OFF_NUMER 8'h20
`define RS_OFF_PIN_CFG 8'h24
// =====================================================================
// per-segment registers: base + 16*n, words +0 inc, +4 len, +8 cfg
`define RS_OFF_SEG_BASE 8'h40
`define RS_SEG_STRIDE_LOG2 4
// =====================================================================
// control fields
`define RS_CTRL_EN_BIT 0
`define RS_CTRL_SHIFT_TRIG_LSB 4
// segment cfg fields
`define RS_CFG_NEXT_LSB 0
`define RS_CFG_ADV_LSB 4
`define RS_CFG_RST_BIT 8
`define RS_CFG_HALF_BIT 9
`define RS_CFG_FLAG_LSB 12
// advance select codes
`define RS_ADV_TIMEOUT 2'd0
`define RS_ADV_TRIG_A 2'd1
`define RS_ADV_TRIG_B 2'd2
`define RS_ADV_TRIG_C 2'd3
// trigger source codes
`define RS_TSRC_OFF 3'd0
`define RS_TSRC_PIN_A_RISE 3'd3
// =====================================================================
// reset values
`define RS_SEG_LEN_RST 16'h0000
`define RS_BUS_ERR_DATA 32'h0000_0000
`endif

//--- rtl/ramp_seq_pkg.sv
/*
 * Types of the ramp segment sequencer.
 * Assumes nothing beyond the constants header.
 */
package ramp_seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_WAIT = 3'b100
  } seq_state_t;
  typedef logic signed [32:0] numer_t;
endpackage

//--- tb/ext_pins.sv
/*
 * Far-side model: a trigger source on pin a and flag consumers on pins b and c.
 * Assumes the bench asks for an edge by raising fire; pins b and c toggle while nobody drives them.
 */
`timescale 1ns/1ps
module ext_pins (
  input wire logic clk, // core clock
  input wire logic fire, // request a high level on pin a
  input wire logic [2:0] dout, // design pin outputs
  input wire logic [2:0] oe, // design output enables
  output logic [2:0] pin, // resolved pin levels
  output int rise_b, // rising edges seen on pin b
  output int rise_c // rising edges seen on pin c
);
  logic a_q = 1'b0;
  logic tog = 1'b0;
  logic [2:0] pin_p = 3'b000;
  // =====================================
  // drive and watch
  initial begin
    rise_b = 0;
    rise_c = 0;
  end
  always @(posedge clk) begin
    tog <= ~tog;
    a_q <= fire;
    pin_p <= pin;
    if (oe[1] && pin[1] && !pin_p[1]) rise_b <= rise_b + 1;
    if (oe[2] && pin[2] && !pin_p[2]) rise_c <= rise_c + 1;
  end
  assign pin[0] = oe[0] ? dout[0] : a_q;
  assign pin[1] = oe[1] ? dout[1] : ~tog;
  assign pin[2] = oe[2] ? dout[2] : tog;
endmodule

//--- tb/tb_top.sv
/*
 * Self-checking bench of the ramp segment sequencer over classic Wishbone.
 * Assumes the design package and header under rtl and the pin model ext_pins.
 */
`timescale 1ns/1ps
`include "ramp_seq_cfg.svh"
module tb_top import ramp_seq_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, fire = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [2:0] pin, dout, oe;
  logic [32:0] numer, last;
  logic [32:0] vq[$];
  int tq[$];
  bit rec = 1'b0;
  int rise_b, rise_c, n_mismatch = 0, n_checks = 0, cyc_n = 0;
  integer seed = 32'ha6a9_efd7;
  ramp_segment_sequencer u_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_PIN(pin),
    .O_PIN(dout), .O_PIN_OE(oe), .O_NUMER(numer));
  ext_pins u_pins (.clk(clk), .fire(fire), .dout(dout), .oe(oe), .pin(pin), .rise_b(rise_b), .rise_c(rise_c));
  always #5 clk = ~clk;
  // =====================================
  // numerator trace and timeout
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (rec && numer !== last) begin
      vq.push_back(numer);
      tq.push_back(cyc_n);
    end
    last <= numer;
  end
  always @(posedge clk) if (cyc_n == 20000) begin
    n_mismatch++;
    results();
  end
  // =====================================
  // tasks
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) n_mismatch++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic pulse_a();
    fire <= 1'b1;
    repeat (4) @(posedge clk);
    fire <= 1'b0;
    repeat (60) @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // seg0 full-rate steps, then seg1 steps of -3 with the shift of 100 applied
  function automatic logic [32:0] ramp_val(input int k, input int i0, input int l0);
    if (k < l0) return 33'(i0 * (k + 1));
    return 33'(i0 * l0 - 3 * (k - l0 + 1) + 100);
  endfunction
  // =====================================
  // main sequence
  initial begin
    logic [31:0] q;
    int i0, l0, j, n, n21;
    int ix[$];
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("numer_rst", 33'h0, numer);
    chk("oe_rst", 33'h0, 33'(oe));
    wb(1'b0, `RS_OFF_CMP_CFG, 32'h0, q);
    chk("cmp_cfg_rst", 33'h0_000F_0000, {1'b0, q});
    wr(8'h30, 32'hFFFF_FFFF);
    wb(1'b0, 8'h30, 32'h0, q);
    chk("unmapped", 33'h0, {1'b0, q});
    for (j = 0; j < 8; j++) begin
      i0 = $random(seed);
      wr(`RS_OFF_SEG_BASE + 8'(j * 16), 32'(i0));
      wb(1'b0, `RS_OFF_SEG_BASE + 8'(j * 16), 32'h0, q);
      chk("seg_inc", {1'b0, 32'(i0)}, {1'b0, q});
    end
    i0 = 4 + ($unsigned($random(seed)) % 12);
    l0 = 4 + ($unsigned($random(seed)) % 8);
    wr(8'h40, 32'(i0));
    wr(8'h44, 32'(l0));
    wr(8'h48, 32'h0000_0011);
    wr(8'h50, 32'hFFFF_FFFD);
    wr(8'h54, 32'h0000_0004);
    wr(8'h58, 32'h0000_2202);
    wr(8'h60, 32'h0000_0007);
    wr(8'h64, 32'h0000_0003);
    wr(8'h68, 32'h0000_0102);
    wr(`RS_OFF_SHIFT_DEV, 32'h0000_0064);
    wr(`RS_OFF_CMPA_THR, 32'h0000_03E8);
    wr(`RS_OFF_CMPB_THR, 32'h0000_0014);
    wr(`RS_OFF_CMP_CFG, 32'h000B_0403);
    wr(`RS_OFF_PIN_CFG, 32'h0000_6003);
    repeat (2) @(posedge clk);
    chk("pin_oe", 33'h6, 33'(oe));
    rec <= 1'b1;
    wr(`RS_OFF_CTRL, 32'h0000_0011);
    j = 0;
    do begin
      wb(1'b0, `RS_OFF_STATUS, 32'h0, q);
      j++;
    end while (q[2:0] !== ST_WAIT && j < 100);
    chk("state_wait", 33'(ST_WAIT), 33'(q[2:0]));
    chk("seg_wait", 33'h0, 33'(q[8:6]));
    wb(1'b0, `RS_OFF_NUMER, 32'h0, q);
    chk("numer_wait", 33'(i0 * l0), {1'b0, q});
    chk("numer_out", 33'(i0 * l0), numer);
    chk("cmp_b_masked", 33'h0, 33'(rise_c));
    pulse_a();
    foreach (vq[k]) if (k < l0 || (vq[k] !== 33'(i0 * l0 + 100) && vq[k] !== 33'd100)) ix.push_back(k);
    chk("trace_len", 33'h1, 33'(ix.size() > l0 + 4));
    for (j = 0; j < l0 + 4; j++) chk("ramp", ramp_val(j, i0, l0), vq[ix[j]]);
    for (j = 1; j < l0; j++) chk("step_full", 33'h1, 33'(tq[ix[j]] - tq[ix[j - 1]]));
    for (j = l0 + 1; j < l0 + 4; j++) chk("step_half", 33'h2, 33'(tq[ix[j]] - tq[ix[j - 1]]));
    n21 = 0;
    for (j = l0 + 4; j < ix.size(); j++) begin
      chk("saw", 33'h1, 33'(vq[ix[j]] inside {33'd107, 33'd114, 33'd121}));
      n21 += (vq[ix[j]] === 33'd121);
    end
    chk("saw_repeat", 33'h1, 33'(n21 >= 3));
    chk("flag_b", 33'h1, 33'(rise_b >= 1));
    chk("cmp_b", 33'h1, 33'(rise_c >= 1));
    pulse_a();
    n = vq.size();
    repeat (30) @(posedge clk);
    for (j = n; j < vq.size(); j++) chk("saw_noshift", 33'h1, 33'(vq[j] inside {33'd0, 33'd7, 33'd14, 33'd21}));
    chk("saw_noshift_len", 33'h1, 33'(vq.size() > n + 3));
    results();
  end
endmodule
